// ===== inc/lkd_pkg.sv
// constants and carrier types for the link diagnostics register page
package lkd_pkg;
    // page and register offsets
    localparam logic [2:0] PAGE_DIAG = 3'h2;
    localparam logic [4:0] ADDR_FREQ = 5'h15;
    localparam logic [4:0] ADDR_REFL = 5'h16;
    // field positions
    localparam int FREQ_TRIG_BIT = 15;
    localparam int FREQ_SEL_BIT = 8;
    localparam int REFL_ON_BIT = 15;
    localparam int REFL_FAST_BIT = 14;
    localparam int REFL_WIDTH_LSB = 8;
    localparam int REFL_WIDTH_MSB = 10;
    // values after reset
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [15:0] REFL_RESET = 16'h0020;
    // signed readback limits
    localparam logic [7:0] OFFSET_MAX = 8'h7f;
    localparam logic [7:0] OFFSET_MIN = 8'h80;
    // slow-mode width code that sends only the pre-emphasis part
    localparam logic [2:0] WIDTH_PRE_ONLY = 3'h1;
    // fetch sequencer states
    typedef enum logic {LKD_IDLE, LKD_FETCH} lkd_fetch_state_t;
    // values offered by the receive signal processor
    typedef struct packed {
        logic [7:0] long_offset;
        logic [7:0] phase_corr;
    } lkd_dsp_sample_t;
    // pulse generator steering
    typedef struct packed {
        logic use_fast;
        logic slow_full;
        logic negative;
    } lkd_pulse_ctrl_t;
endpackage : lkd_pkg

// ===== design/lkd_regs.sv
// link diagnostics page: frequency offset readout and reflectometry control
// Behaviour
// - trigger with selector 0 fetches long-term offset
// - trigger with selector 1 fetches control value
// - sample trigger always reads back zero
// - bits 14:9 ignore writes, read zero
// - readback is signed, 0x7f to 0x80
// - control value is offset plus phase correction
// - reflectometry enable forces test power-up state
// - bit 14 selects fast transmitter, 8 ns
// - fast-mode pulses alternate polarity
// - bit 14 clear uses slow link pulse
`timescale 1ns/1ps
module lkd_regs (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // management register access
    input wire logic [2:0] page_selector,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    // signal processor fetch handshake
    output logic dsp_fetch_req,
    output logic dsp_fetch_ctrl,
    input wire logic dsp_ack,
    input wire lkd_pkg::lkd_dsp_sample_t dsp_sample,
    // reflectometry side
    input wire logic tdr_pulse_sent,
    output logic tdr_force_power,
    output lkd_pkg::lkd_pulse_ctrl_t pulse_ctrl,
    output logic [2:0] tdr_width
);
    // clamp a signed 8-bit sum into the readback range
    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {a[7], a} + {b[7], b};
        if (s[8] != s[7]) begin
            return s[8] ? lkd_pkg::OFFSET_MIN : lkd_pkg::OFFSET_MAX;
        end
        return s[7:0];
    endfunction : sat_add

    lkd_pkg::lkd_fetch_state_t state_q;
    logic sel_q;
    logic sel_fetch_q;
    logic [7:0] offset_q;
    logic [15:0] refl_q;
    logic neg_q;
    logic page_ok;
    logic wr_freq;
    logic wr_refl;
    logic rd_freq;
    logic rd_refl;
    logic fetch_done;

    // register decode, only on the diagnostics page
    assign page_ok = (page_selector == lkd_pkg::PAGE_DIAG);
    assign wr_freq = mgmt_wr && page_ok && (mgmt_addr == lkd_pkg::ADDR_FREQ);
    assign wr_refl = mgmt_wr && page_ok && (mgmt_addr == lkd_pkg::ADDR_REFL);
    assign rd_freq = mgmt_rd && page_ok && (mgmt_addr == lkd_pkg::ADDR_FREQ);
    assign rd_refl = mgmt_rd && page_ok && (mgmt_addr == lkd_pkg::ADDR_REFL);
    assign fetch_done = (state_q == lkd_pkg::LKD_FETCH) && dsp_ack;

    // fetch handshake towards the signal processor
    assign dsp_fetch_req = (state_q == lkd_pkg::LKD_FETCH);
    assign dsp_fetch_ctrl = sel_fetch_q;

    // selector bit, plain read/write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_q <= 1'b0;
        end else if (clk_en && wr_freq) begin
            sel_q <= mgmt_wdata[lkd_pkg::FREQ_SEL_BIT];
        end
    end

    // fetch sequencer, started by a one written to the trigger
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= lkd_pkg::LKD_IDLE;
            sel_fetch_q <= 1'b0;
        end else if (clk_en) begin
            case (state_q)
                lkd_pkg::LKD_IDLE: begin
                    if (wr_freq && mgmt_wdata[lkd_pkg::FREQ_TRIG_BIT]) begin
                        state_q <= lkd_pkg::LKD_FETCH;
                        sel_fetch_q <= mgmt_wdata[lkd_pkg::FREQ_SEL_BIT];
                    end
                end
                lkd_pkg::LKD_FETCH: begin
                    if (dsp_ack) begin
                        state_q <= lkd_pkg::LKD_IDLE;
                    end
                end
                default: begin
                    state_q <= lkd_pkg::LKD_IDLE;
                end
            endcase
        end
    end

    // readback capture; untouched between fetches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            offset_q <= lkd_pkg::OFFSET_RESET;
        end else if (clk_en && fetch_done) begin
            if (sel_fetch_q) begin
                offset_q <= sat_add(dsp_sample.long_offset, dsp_sample.phase_corr);
            end else begin
                offset_q <= dsp_sample.long_offset;
            end
        end
    end

    // reflectometry control register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            refl_q <= lkd_pkg::REFL_RESET;
        end else if (clk_en && wr_refl) begin
            refl_q <= mgmt_wdata;
        end
    end

    // polarity of fast-mode pulses flips on each pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            neg_q <= 1'b0;
        end else if (clk_en) begin
            if (!refl_q[lkd_pkg::REFL_ON_BIT] || !refl_q[lkd_pkg::REFL_FAST_BIT]) begin
                neg_q <= 1'b0;
            end else if (tdr_pulse_sent) begin
                neg_q <= ~neg_q;
            end
        end
    end

    // pulse generator steering and power-up override
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tdr_force_power <= 1'b0;
            pulse_ctrl <= '0;
            tdr_width <= 3'h0;
        end else if (clk_en) begin
            tdr_force_power <= refl_q[lkd_pkg::REFL_ON_BIT];
            pulse_ctrl.use_fast <= refl_q[lkd_pkg::REFL_FAST_BIT];
            pulse_ctrl.slow_full <= !refl_q[lkd_pkg::REFL_FAST_BIT] &&
                (refl_q[lkd_pkg::REFL_WIDTH_MSB:lkd_pkg::REFL_WIDTH_LSB] !=
                 lkd_pkg::WIDTH_PRE_ONLY);
            pulse_ctrl.negative <= neg_q;
            tdr_width <= refl_q[lkd_pkg::REFL_WIDTH_MSB:lkd_pkg::REFL_WIDTH_LSB];
        end
    end

    // registered read data; other addresses and pages read zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mgmt_rdata <= 16'h0000;
        end else if (clk_en && mgmt_rd) begin
            if (rd_freq) begin
                mgmt_rdata <= {7'h00, sel_q, offset_q};
            end else if (rd_refl) begin
                mgmt_rdata <= refl_q;
            end else begin
                mgmt_rdata <= 16'h0000;
            end
        end
    end

    // reference for the saturated control value, clamped by signed compares
    logic signed [8:0] ref_sum;
    logic [7:0] ref_ctrl;
    assign ref_sum = $signed({dsp_sample.long_offset[7], dsp_sample.long_offset}) +
        $signed({dsp_sample.phase_corr[7], dsp_sample.phase_corr});
    assign ref_ctrl = (ref_sum > 9'sd127) ? lkd_pkg::OFFSET_MAX :
        ((ref_sum < -9'sd128) ? lkd_pkg::OFFSET_MIN : ref_sum[7:0]);

    // checks
    a_trigger_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && rd_freq) |=> !mgmt_rdata[lkd_pkg::FREQ_TRIG_BIT])
        else $error("trigger bit read back as one");
    a_reserved_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && rd_freq) |=> (mgmt_rdata[14:9] == 6'h00))
        else $error("reserved bits not zero");
    a_fetch_kind_select: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && wr_freq && mgmt_wdata[lkd_pkg::FREQ_TRIG_BIT] &&
         state_q == lkd_pkg::LKD_IDLE) |=>
        dsp_fetch_req && (dsp_fetch_ctrl == $past(mgmt_wdata[lkd_pkg::FREQ_SEL_BIT])))
        else $error("fetch kind not taken from selector");
    a_fetch_long_offset: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && fetch_done && !sel_fetch_q) |=> offset_q == $past(dsp_sample.long_offset))
        else $error("long-term offset not captured");
    a_fetch_ctrl_sum: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && fetch_done && sel_fetch_q) |=> offset_q == $past(ref_ctrl))
        else $error("control value not offset plus correction");
    a_ctrl_sign_range: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && fetch_done && sel_fetch_q && !dsp_sample.long_offset[7] &&
         !dsp_sample.phase_corr[7]) |=> !offset_q[7])
        else $error("positive sum wrapped negative");
    a_readback_hold: assert property (@(posedge core_clk) disable iff (rst)
        !(clk_en && fetch_done) |=> $stable(offset_q))
        else $error("readback changed without fetch");
    a_power_follows_on: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && wr_refl) ##1 clk_en |=>
        tdr_force_power == $past(mgmt_wdata[lkd_pkg::REFL_ON_BIT], 2))
        else $error("power override not following enable");
    a_fast_select: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && wr_refl) ##1 clk_en |=>
        pulse_ctrl.use_fast == $past(mgmt_wdata[lkd_pkg::REFL_FAST_BIT], 2))
        else $error("fast transmitter select wrong");
    a_polarity_alternate: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && tdr_pulse_sent && refl_q[lkd_pkg::REFL_ON_BIT] &&
         refl_q[lkd_pkg::REFL_FAST_BIT]) |=> neg_q != $past(neg_q))
        else $error("fast pulse polarity did not alternate");
    a_slow_pre_only: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && wr_refl && !mgmt_wdata[lkd_pkg::REFL_FAST_BIT] &&
         mgmt_wdata[lkd_pkg::REFL_WIDTH_MSB:lkd_pkg::REFL_WIDTH_LSB] == lkd_pkg::WIDTH_PRE_ONLY)
        ##1 clk_en |=> !pulse_ctrl.slow_full)
        else $error("pre-emphasis pulse not chosen");
    a_page_gate: assert property (@(posedge core_clk) disable iff (rst)
        (mgmt_wr && page_selector != lkd_pkg::PAGE_DIAG) |=> $stable(refl_q) && $stable(sel_q))
        else $error("write taken on wrong page");
    c_fetch_long: cover property (@(posedge core_clk) disable iff (rst)
        clk_en && fetch_done && !sel_fetch_q);
    c_fetch_ctrl: cover property (@(posedge core_clk) disable iff (rst)
        clk_en && fetch_done && sel_fetch_q);
    c_fast_two_pulses: cover property (@(posedge core_clk) disable iff (rst)
        (clk_en && tdr_pulse_sent && refl_q[14]) ##[1:20] (clk_en && tdr_pulse_sent));
endmodule : lkd_regs

// ===== test/test_link_diag_freq_tdr_regs.sv
// self-checking bench for the link diagnostics register page
`timescale 1ns/1ps
module test_link_diag_freq_tdr_regs;
    // design connections
    logic core_clk, rst, clk_en, mgmt_wr, mgmt_rd, dsp_ack, tdr_pulse_sent;
    logic [2:0] page_selector;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, v;
    logic dsp_fetch_req, dsp_fetch_ctrl, tdr_force_power;
    lkd_pkg::lkd_dsp_sample_t dsp_sample;
    lkd_pkg::lkd_pulse_ctrl_t pulse_ctrl;
    logic [2:0] tdr_width;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    lkd_regs dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .page_selector(page_selector), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .dsp_fetch_req(dsp_fetch_req), .dsp_fetch_ctrl(dsp_fetch_ctrl), .dsp_ack(dsp_ack),
        .dsp_sample(dsp_sample), .tdr_pulse_sent(tdr_pulse_sent),
        .tdr_force_power(tdr_force_power), .pulse_ctrl(pulse_ctrl), .tdr_width(tdr_width));
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // watchdog against a hung handshake
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one management write, strobe high for one taken edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [2:0] pg);
        @(posedge core_clk);
        page_selector <= pg;
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr <= 1'b1;
        @(posedge core_clk);
        mgmt_wr <= 1'b0;
        #1;
    endtask : wr
    // one management read, data settled after the taking edge
    task automatic rd(input logic [4:0] a, input logic [2:0] pg);
        @(posedge core_clk);
        page_selector <= pg;
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge core_clk);
        mgmt_rd <= 1'b0;
        #1 v = mgmt_rdata;
    endtask : rd
    // trigger a fetch, answer it, then check readback and that it holds
    task automatic fetch(input logic [15:0] cmd, input logic [7:0] lo, input logic [7:0] ph,
                         input logic [7:0] exp);
        wr(lkd_pkg::ADDR_FREQ, cmd, 3'h2);
        for (int i = 0; i < 8 && dsp_fetch_req !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("fetch_req", 16'h1, {15'h0, dsp_fetch_req});
        chk("fetch_ctrl", {15'h0, cmd[8]}, {15'h0, dsp_fetch_ctrl});
        @(posedge core_clk);
        dsp_ack <= 1'b1;
        dsp_sample <= {lo, ph};
        @(posedge core_clk);
        dsp_ack <= 1'b0;
        dsp_sample <= ~{lo, ph};
        #1 chk("fetch_req", 16'h0, {15'h0, dsp_fetch_req});
        rd(lkd_pkg::ADDR_FREQ, 3'h2);
        chk("freq_reg", {7'h0, cmd[8], exp}, v);
        // stray acknowledge with no fetch pending leaves readback alone
        @(posedge core_clk);
        dsp_ack <= 1'b1;
        @(posedge core_clk);
        dsp_ack <= 1'b0;
        rd(lkd_pkg::ADDR_FREQ, 3'h2);
        chk("freq_hold", {7'h0, cmd[8], exp}, v);
        $display("test fetch %h done", cmd);
    endtask : fetch
    // one transmitted pulse, then let the polarity register settle
    task automatic pulse();
        @(posedge core_clk);
        tdr_pulse_sent <= 1'b1;
        @(posedge core_clk);
        tdr_pulse_sent <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : pulse
    // write reflect register and check steering outputs after they follow
    task automatic refl(input logic [15:0] d, input logic [15:0] exp_pc);
        wr(lkd_pkg::ADDR_REFL, d, 3'h2);
        repeat (2) @(posedge core_clk);
        #1 chk("force_power", {15'h0, d[15]}, {15'h0, tdr_force_power});
        chk("pulse_ctrl", exp_pc, {13'h0, pulse_ctrl});
        chk("tdr_width", {13'h0, d[10:8]}, {13'h0, tdr_width});
    endtask : refl
    task automatic refl_test();
        refl(16'hc000, 16'h4);
        pulse();
        chk("negative", 16'h5, {13'h0, pulse_ctrl});
        pulse();
        chk("negative", 16'h4, {13'h0, pulse_ctrl});
        rd(lkd_pkg::ADDR_REFL, 3'h2);
        chk("refl_reg", 16'hc000, v);
        refl(16'h8100, 16'h0);
        pulse();
        chk("slow_pulse", 16'h0, {13'h0, pulse_ctrl});
        refl(16'h8200, 16'h2);
        // another page neither writes nor reads this register
        wr(lkd_pkg::ADDR_REFL, 16'h1234, 3'h1);
        rd(lkd_pkg::ADDR_REFL, 3'h1);
        chk("other_page", 16'h0, v);
        rd(lkd_pkg::ADDR_REFL, 3'h2);
        chk("refl_reg", 16'h8200, v);
        // enable cleared drops the power override again
        refl(16'h0000, 16'h2);
        $display("test reflect done");
    endtask : refl_test
    // a write while the clock enable is low must leave the register alone
    task automatic freeze();
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(lkd_pkg::ADDR_REFL, 16'h1111, 3'h2);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd(lkd_pkg::ADDR_REFL, 3'h2);
        chk("frozen_write", 16'h0000, v);
        $display("test freeze done");
    endtask : freeze
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        {rst, clk_en, mgmt_wr, mgmt_rd, dsp_ack, tdr_pulse_sent} = 6'h30;
        {page_selector, mgmt_addr, mgmt_wdata, dsp_sample} = '0;
        clk_en = 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(lkd_pkg::ADDR_FREQ, 3'h2);
        chk("freq_reset", {8'h0, lkd_pkg::OFFSET_RESET}, v);
        rd(lkd_pkg::ADDR_REFL, 3'h2);
        chk("refl_reset", lkd_pkg::REFL_RESET, v);
        $display("test reset done");
        fetch(16'hfe00, 8'h80, 8'h05, 8'h80);
        fetch(16'h8100, 8'h10, 8'hf0, 8'h00);
        fetch(16'h8100, 8'h7f, 8'h01, 8'h7f);
        fetch(16'h8100, 8'h80, 8'hff, 8'h80);
        refl_test();
        freeze();
        results();
    end
endmodule : test_link_diag_freq_tdr_regs
